// ==== common/sha_pkg.sv ====
/*
 * shared constants and types of the sha3-384 hash engine.
 * assumes: 64-bit keccak lanes, 32-bit stream words, one clock domain.
 */
package sha_pkg;
   localparam int unsigned SHA_WORD_W      = 32;  // stream word width
   localparam int unsigned SHA_FIFO_DEPTH  = 16;  // words of input buffering
   localparam int unsigned SHA_LANE_W      = 64;  // keccak lane width
   localparam int unsigned SHA_LANES       = 25;  // 5 x 5 lanes of state
   localparam int unsigned SHA_HASH_LANES  = 6;   // 384 bits of digest
   localparam int unsigned SHA_HASH_W      = 384; // digest width
   localparam int unsigned SHA_BLOCK_BYTES = 104; // rate of sha3-384
   localparam int unsigned SHA_BLOCK_WORDS = SHA_BLOCK_BYTES / (SHA_WORD_W / 8);
   localparam int unsigned SHA_ROUNDS      = 24;  // keccak-f rounds, one per cycle

   localparam logic [4:0] SHA_WORD_LAST  = 5'h1_9;  // index of 26th word in a block
   localparam logic [4:0] SHA_ROUND_LAST = 5'h1_7;  // index of 24th round
   localparam logic [7:0] SHA_LFSR_INIT  = 8'h01;   // round constant generator seed
   localparam logic [7:0] SHA_LFSR_POLY  = 8'h71;   // x^8+x^6+x^5+x^4+1, top bit dropped
   localparam logic       SHA_PAD_RESET  = 1'b0;    // 0 = nist padding after reset

   // rotation of each lane, indexed x + 5*y
   localparam int unsigned SHA_RHO_OFFSET [SHA_LANES] = '{
      0, 1, 62, 28, 27, 36, 44, 6, 55, 20, 3, 10, 43,
      25, 39, 41, 45, 15, 21, 8, 18, 2, 61, 56, 14};

   typedef logic [SHA_LANES-1:0][SHA_LANE_W-1:0] sha_lanes_type;  // whole keccak state

   typedef enum logic [1:0] {
      SHA_IDLE,
      SHA_ABSORB,
      SHA_PERMUTE,
      SHA_DONE
   } sha_state_type;
endpackage

// ==== common/sha_stream_if.sv ====
/*
 * valid/ready word stream between the engine's own modules.
 * assumes: transfer when valid and ready are both high at a clock edge.
 */
`timescale 1ns/1ps
interface sha_stream_if #(parameter int unsigned WIDTH = 32);
   logic [WIDTH-1:0] data;   // word carried
   logic             valid;  // source offers a word
   logic             ready;  // sink takes the word

   modport source (output data, output valid, input ready);
   modport sink   (input data, input valid, output ready);
endinterface

// ==== rtl/sha_fifo.sv ====
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes: synchronous active-low reset, writer and reader on one clock.
 */
`timescale 1ns/1ps
module sha_fifo
   import sha_pkg::*;
#(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic   clk_sys,
   input  wire logic   reset_n,
   sha_stream_if.sink   wr_port,
   sha_stream_if.source rd_port
);
   localparam int unsigned PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];   // storage, no reset needed
   logic [PTR_W-1:0] wr_ptr_reg;        // next slot to fill
   logic [PTR_W-1:0] wr_ptr_next;
   logic [PTR_W-1:0] rd_ptr_reg;        // oldest word
   logic [PTR_W-1:0] rd_ptr_next;
   logic [PTR_W:0]   count_reg;         // words held
   logic [PTR_W:0]   count_next;
   logic             ready_reg;         // registered not-full
   logic             ready_next;
   logic             push;
   logic             pop;

   assign wr_port.ready = ready_reg;
   assign rd_port.valid = (count_reg != '0);
   assign rd_port.data  = mem_reg[rd_ptr_reg];

   // pointer and level bookkeeping
   always_comb begin
      push        = wr_port.valid && ready_reg;
      pop         = rd_port.valid && rd_port.ready;
      wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_next  = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
      // full is honest: a stalled reader lets the buffer fill and stall the source
      ready_next = (count_next != (PTR_W + 1)'(DEPTH));
   end

   // state registers
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         ready_reg  <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         ready_reg  <= ready_next;
      end
   end

   // storage write
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= wr_port.data;
      end
   end
endmodule

// ==== rtl/sha_engine.sv ====
/*
 * sha3-384 hash engine: input fifo, absorb of 104-byte blocks,
 * keccak-f[1600] permutation at one round per clock, digest register.
 * assumes: the stream source delivers whole, already padded blocks,
 * and marks the final block through last_update before its last word.
 */
`timescale 1ns/1ps
module sha_engine
   import sha_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   input  wire logic                  core_reset_hold,
   input  wire logic                  start,
   input  wire logic                  last_update,
   input  wire logic                  pad_select_nist,
   input  wire logic                  pad_select_keccak,
   input  wire logic [SHA_WORD_W-1:0] s_data,
   input  wire logic                  s_valid,
   output logic                       s_ready,
   output logic                       busy,
   output logic                       done,
   output logic                       padding_scheme_select,
   output logic [SHA_HASH_W-1:0]      hash_out
);
   // rotate a lane left; a zero count leaves it unchanged
   function automatic logic [SHA_LANE_W-1:0] rotl(input logic [SHA_LANE_W-1:0] v,
                                                  input int unsigned n);
      rotl = (v << n) | (v >> (SHA_LANE_W - n));
   endfunction

   // one round constant from the lfsr, returned with the advanced lfsr
   function automatic logic [SHA_LANE_W+7:0] round_const(input logic [7:0] r);
      logic [SHA_LANE_W-1:0] rc;
      logic [7:0]            s;
      rc = '0;
      s  = r;
      for (int j = 0; j < 7; j++) begin
         rc[(1 << j) - 1] = s[0];
         s = {s[6:0], 1'b0} ^ (s[7] ? SHA_LFSR_POLY : 8'h00);
      end
      round_const = {s, rc};
   endfunction

   // theta, rho, pi, chi and iota of keccak-f[1600]
   function automatic sha_lanes_type keccak_round(input sha_lanes_type a,
                                                  input logic [SHA_LANE_W-1:0] rc);
      sha_lanes_type                    b;
      logic [4:0][SHA_LANE_W-1:0]       c;
      logic [4:0][SHA_LANE_W-1:0]       d;
      b = '0;
      c = '0;
      d = '0;
      for (int x = 0; x < 5; x++) begin
         c[x] = a[x] ^ a[x+5] ^ a[x+10] ^ a[x+15] ^ a[x+20];
      end
      for (int x = 0; x < 5; x++) begin
         d[x] = c[(x+4)%5] ^ rotl(c[(x+1)%5], 1);
      end
      for (int x = 0; x < 5; x++) begin
         for (int y = 0; y < 5; y++) begin
            b[y + 5*((2*x + 3*y) % 5)] = rotl(a[x + 5*y] ^ d[x], SHA_RHO_OFFSET[x + 5*y]);
         end
      end
      for (int x = 0; x < 5; x++) begin
         for (int y = 0; y < 5; y++) begin
            a[x + 5*y] = b[x + 5*y] ^ (~b[(x+1)%5 + 5*y] & b[(x+2)%5 + 5*y]);
         end
      end
      a[0] = a[0] ^ rc;
      keccak_round = a;
   endfunction

   logic                  core_rst_n;        // board reset or held by control
   sha_state_type         state_reg;         // engine sequencer
   sha_state_type         state_next;
   sha_lanes_type         lanes_reg;         // keccak state
   sha_lanes_type         lanes_next;
   logic [4:0]            word_reg;          // word index inside block
   logic [4:0]            word_next;
   logic [4:0]            round_reg;         // round index inside permutation
   logic [4:0]            round_next;
   logic [7:0]            lfsr_reg;          // round constant generator
   logic [7:0]            lfsr_next;
   logic                  last_armed_reg;    // final update announced
   logic                  last_armed_next;
   logic                  final_reg;         // block in flight is the last one
   logic                  final_next;
   logic                  keccak_reg;        // 1 = keccak padding chosen
   logic                  keccak_next;
   logic                  done_reg;
   logic                  done_next;
   logic                  busy_reg;
   logic                  busy_next;
   logic [SHA_HASH_W-1:0] hash_reg;          // digest visible to software
   logic [SHA_HASH_W-1:0] hash_next;
   logic [SHA_LANE_W+7:0] rc_pack;           // advanced lfsr and round constant

   sha_stream_if #(.WIDTH(SHA_WORD_W)) in_if ();
   sha_stream_if #(.WIDTH(SHA_WORD_W)) blk_if ();

   // the hold input keeps the whole core, buffer included, in reset
   assign core_rst_n = reset_n && !core_reset_hold;

   // dma stream enters only through the buffer
   assign in_if.data  = s_data;
   assign in_if.valid = s_valid;
   assign s_ready     = in_if.ready;

   sha_fifo #(
      .WIDTH (SHA_WORD_W),
      .DEPTH (SHA_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys (clk_sys),
      .reset_n (core_rst_n),
      .wr_port (in_if),
      .rd_port (blk_if)
   );

   assign busy                  = busy_reg;
   assign done                  = done_reg;
   assign padding_scheme_select = keccak_reg;
   assign hash_out              = hash_reg;

   // sequencer next values
   always_comb begin
      state_next      = state_reg;
      lanes_next      = lanes_reg;
      word_next       = word_reg;
      round_next      = round_reg;
      lfsr_next       = lfsr_reg;
      last_armed_next = last_armed_reg;
      final_next      = final_reg;
      keccak_next     = keccak_reg;
      done_next       = done_reg;
      hash_next       = hash_reg;
      rc_pack         = round_const(lfsr_reg);
      // buffer drains only while absorbing, so a permuting core back-pressures the dma
      blk_if.ready    = (state_reg == SHA_ABSORB);

      unique case (state_reg)
         SHA_IDLE: begin
            // waits for start; words stay buffered
         end
         SHA_ABSORB: begin
            if (blk_if.valid) begin
               // little-endian: even word to low half of its lane
               if (word_reg[0]) begin
                  lanes_next[word_reg[4:1]][63:32] = lanes_reg[word_reg[4:1]][63:32] ^ blk_if.data;
               end else begin
                  lanes_next[word_reg[4:1]][31:0] = lanes_reg[word_reg[4:1]][31:0] ^ blk_if.data;
               end
               // a block is taken only whole, 26 words of 104 bytes
               if (word_reg == SHA_WORD_LAST) begin
                  word_next  = '0;
                  round_next = '0;
                  lfsr_next  = SHA_LFSR_INIT;
                  final_next = last_armed_reg;
                  state_next = SHA_PERMUTE;
               end else begin
                  word_next = word_reg + 5'h01;
               end
            end
         end
         SHA_PERMUTE: begin
            lanes_next = keccak_round(lanes_reg, rc_pack[SHA_LANE_W-1:0]);
            lfsr_next  = rc_pack[SHA_LANE_W+7:SHA_LANE_W];
            round_next = round_reg + 5'h01;
            if (round_reg == SHA_ROUND_LAST) begin
               // digest refreshed after every block, readable mid-hash
               hash_next = SHA_HASH_W'(lanes_next[SHA_HASH_LANES-1:0]);
               if (final_reg) begin
                  state_next = SHA_DONE;
                  done_next  = 1'b1;
               end else begin
                  // further updates keep accumulating into the same state
                  state_next = SHA_ABSORB;
               end
            end
         end
         SHA_DONE: begin
            // digest and done hold until start or reset
         end
      endcase

      // a fresh hash clears sequencer, keccak state and digest; buffered words and the padding choice survive
      if (start) begin
         state_next      = SHA_ABSORB;
         lanes_next      = '0;
         word_next       = '0;
         round_next      = '0;
         lfsr_next       = SHA_LFSR_INIT;
         final_next      = 1'b0;
         last_armed_next = 1'b0;
         done_next       = 1'b0;
         hash_next       = '0;
      end
      // announced after start so a same-cycle pair still arms
      if (last_update) begin
         last_armed_next = 1'b1;
      end
      // padding choice survives start; only reset or pad_select_nist returns it to nist
      if (pad_select_keccak) begin
         keccak_next = 1'b1;
      end else if (pad_select_nist) begin
         keccak_next = 1'b0;
      end
      busy_next = (state_next == SHA_ABSORB) || (state_next == SHA_PERMUTE);
   end

   // sequencer registers
   always_ff @(posedge clk_sys) begin
      if (!core_rst_n) begin
         state_reg      <= SHA_IDLE;
         lanes_reg      <= '0;
         word_reg       <= '0;
         round_reg      <= '0;
         lfsr_reg       <= SHA_LFSR_INIT;
         last_armed_reg <= 1'b0;
         final_reg      <= 1'b0;
         keccak_reg     <= SHA_PAD_RESET;
         done_reg       <= 1'b0;
         busy_reg       <= 1'b0;
         hash_reg       <= '0;
      end else begin
         state_reg      <= state_next;
         lanes_reg      <= lanes_next;
         word_reg       <= word_next;
         round_reg      <= round_next;
         lfsr_reg       <= lfsr_next;
         last_armed_reg <= last_armed_next;
         final_reg      <= final_next;
         keccak_reg     <= keccak_next;
         done_reg       <= done_next;
         busy_reg       <= busy_next;
         hash_reg       <= hash_next;
      end
   end
endmodule

// ==== test/sha_engine_asserts.sv ====
/* port checker for the sha3-384 engine.
   assumes: bound to sha_engine, one clock, reset_n sync active low. */
`timescale 1ns/1ps
module sha_engine_asserts
   import sha_pkg::*;
(
   input wire logic                  clk_sys,
   input wire logic                  reset_n,
   input wire logic                  core_reset_hold,
   input wire logic                  start,
   input wire logic                  last_update,
   input wire logic                  pad_select_nist,
   input wire logic                  pad_select_keccak,
   input wire logic [SHA_WORD_W-1:0] s_data,
   input wire logic                  s_valid,
   input wire logic                  s_ready,
   input wire logic                  busy,
   input wire logic                  done,
   input wire logic                  padding_scheme_select,
   input wire logic [SHA_HASH_W-1:0] hash_out
);
   logic was_rst_reg;   // a reset was seen at the previous edge
   logic was_rst_next;  // next value of the above
   // edges right after a reset compare against cleared values, so skip them
   always_comb was_rst_next = !reset_n || core_reset_hold;
   always_ff @(posedge clk_sys) was_rst_reg <= was_rst_next;
   default clocking @(posedge clk_sys); endclocking
   // the core hold clears state like a reset
   default disable iff (!reset_n || core_reset_hold);
   // fresh run: cleared digest, then busy and not done for eight more cycles
   sequence run_open_s;
      busy && !done && hash_out == '0 ##1 (busy && !done)[*8];
   endsequence
   // end of run: done stands and busy is gone
   sequence run_close_s;
      done && !busy;
   endsequence
   hold_clear_a: assert property (disable iff (!reset_n) core_reset_hold
      |=> !s_ready && !busy && !done && !padding_scheme_select && hash_out == '0)
      else $error("outputs not cleared by core hold");
   pad_keccak_a: assert property (pad_select_keccak |=> padding_scheme_select)
      else $error("keccak choice not taken");
   pad_nist_a: assert property (pad_select_nist && !pad_select_keccak
      |=> !padding_scheme_select) else $error("nist choice not taken");
   pad_hold_a: assert property (!pad_select_nist && !pad_select_keccak
      |=> $stable(padding_scheme_select)) else $error("padding choice drifted");
   start_clear_a: assert property (start |=> run_open_s)
      else $error("start did not open a clean run");
   done_close_a: assert property ($fell(busy) && !was_rst_reg |-> run_close_s)
      else $error("busy fell without done");
   done_keep_a: assert property (done && !start
      |=> done && !busy && $stable(hash_out)) else $error("final digest moved");
   hash_step_a: assert property (busy && $changed(hash_out) && !was_rst_reg
      |=> $stable(hash_out)[*8]) else $error("intermediate digest unstable");
   busy_cause_a: assert property ($rose(busy) |-> $past(start))
      else $error("busy rose without start");
   ready_fall_a: assert property ($fell(s_ready) && !was_rst_reg |-> $past(s_valid))
      else $error("ready fell with no word offered");
endmodule

// ==== test/sha_dma_model.sv ====
/* dma-side stream source feeding the engine input.
   assumes: bench queues padded words; flush aborts the transfer. */
`timescale 1ns/1ps
module sha_dma_model
   import sha_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             flush,
   input  wire logic             stall,
   input  wire logic             s_ready,
   output logic [SHA_WORD_W-1:0] s_data,
   output logic                  s_valid
);
   logic [SHA_WORD_W-1:0] words_q [$];  // words not yet offered
   initial s_valid = 1'b0;
   initial s_data = '0;
   // queue one word of a whole padded block
   task automatic push(input logic [SHA_WORD_W-1:0] w);
      words_q.push_back(w);
   endtask
   // offer a word and hold it until taken; idle data flips so nothing stale passes
   always @(posedge clk_sys) begin
      if (flush) begin
         words_q.delete();
         s_valid <= 1'b0;
         s_data  <= ~s_data;
      end else if (!(s_valid && !s_ready) && !stall && words_q.size() != 0) begin
         s_valid <= 1'b1;
         s_data  <= words_q.pop_front();
      end else if (!(s_valid && !s_ready)) begin
         s_valid <= 1'b0;
         s_data  <= ~s_data;
      end
   end
endmodule

// ==== test/tb_top.sv ====
/* self-checking bench for the sha3-384 engine with a keccak reference.
   assumes: package, interface, fifo, engine, dma model, checker compiled first. */
`timescale 1ns/1ps
module tb_top
   import sha_pkg::*;
();
   logic                  clk_sys = 1'b0;
   logic                  reset_n = 1'b0;
   logic                  core_reset_hold = 1'b0;
   logic                  start = 1'b0;
   logic                  last_update = 1'b0;
   logic                  pad_select_nist = 1'b0;
   logic                  pad_select_keccak = 1'b0;
   logic                  stall = 1'b0;       // dma pauses this cycle
   logic                  slow = 1'b0;        // lets the dma pause
   logic [SHA_WORD_W-1:0] s_data;
   logic                  s_valid;
   logic                  s_ready;
   logic                  busy;
   logic                  done;
   logic                  padding_scheme_select;
   logic [SHA_HASH_W-1:0] hash_out;
   logic [7:0]            lfsr_reg = 8'h55;   // random source
   logic [63:0]           st [25];            // reference keccak state
   int                    failures = 0;
   int                    n_compared = 0;
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) stall <= slow && rnd() < 8'h60;
   sha_engine u_dut (.clk_sys, .reset_n, .core_reset_hold, .start, .last_update,
      .pad_select_nist, .pad_select_keccak, .s_data, .s_valid, .s_ready, .busy, .done,
      .padding_scheme_select, .hash_out);
   sha_dma_model u_dma (.clk_sys, .flush(!reset_n || core_reset_hold), .stall, .s_ready,
      .s_data, .s_valid);
   function automatic logic [7:0] rnd();
      lfsr_reg = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      return lfsr_reg;
   endfunction
   task automatic chk(input logic [SHA_HASH_W-1:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   // 24 rounds of keccak-f on the reference state
   function automatic void permute();
      logic [63:0] c [5];
      logic [63:0] b [25];
      logic [7:0]  r;
      int          k;
      r = SHA_LFSR_INIT;
      for (int n = 0; n < SHA_ROUNDS; n++) begin
         for (int x = 0; x < 5; x++) c[x] = st[x] ^ st[x+5] ^ st[x+10] ^ st[x+15] ^ st[x+20];
         for (int i = 0; i < 25; i++) begin
            st[i] ^= c[(i+4)%5] ^ {c[(i+1)%5][62:0], c[(i+1)%5][63]};
            k = SHA_RHO_OFFSET[i];
            b[i/5 + 5*((2*(i%5) + 3*(i/5)) % 5)] = (st[i] << k) | (st[i] >> (64 - k));
         end
         for (int i = 0; i < 25; i++) st[i] = b[i] ^ (~b[i-i%5+(i+1)%5] & b[i-i%5+(i+2)%5]);
         for (int j = 0; j < 7; j++) begin
            if (r[0]) st[0][(1<<j)-1] ^= 1'b1;
            r = r[7] ? {r[6:0], 1'b0} ^ SHA_LFSR_POLY : {r[6:0], 1'b0};
         end
      end
   endfunction
   task automatic push_blk(ref logic [7:0] q [$], input int b);
      for (int m = b * SHA_BLOCK_WORDS; m < (b + 1) * SHA_BLOCK_WORDS; m++)
         u_dma.push({q[4*m+3], q[4*m+2], q[4*m+1], q[4*m]});
   endtask
   // hash nb random bytes; pre loads the first block before start
   task automatic run_hash(input int nb, input bit kec, input bit pre);
      logic [7:0]            q [$];
      logic [SHA_HASH_W-1:0] exp;
      int                    nblk;
      for (int i = 0; i < nb; i++) q.push_back(rnd());
      q.push_back(kec ? 8'h01 : 8'h06);
      while (q.size() % SHA_BLOCK_BYTES != 0) q.push_back(8'h00);
      q[q.size()-1] |= 8'h80;
      nblk = q.size() / SHA_BLOCK_BYTES;
      for (int i = 0; i < 25; i++) st[i] = '0;
      @(posedge clk_sys);
      pad_select_keccak <= kec;
      pad_select_nist <= !kec;
      @(posedge clk_sys);
      pad_select_keccak <= 1'b0;
      pad_select_nist <= 1'b0;
      @(negedge clk_sys);
      chk(padding_scheme_select, kec, "padding choice");
      if (pre) begin
         push_blk(q, 0);
         repeat (30) @(negedge clk_sys);
         chk(s_ready, 1'b0, "fifo should refuse when full");
      end
      @(posedge clk_sys);
      start <= 1'b1;
      last_update <= (nblk == 1);
      @(posedge clk_sys);
      start <= 1'b0;
      last_update <= 1'b0;
      @(negedge clk_sys);
      chk(hash_out, '0, "start clears digest");
      for (int b = 0; b < nblk; b++) begin
         if (b == nblk - 1 && b > 0) begin
            @(posedge clk_sys) last_update <= 1'b1;
            @(posedge clk_sys) last_update <= 1'b0;
         end
         if (!pre || b > 0) push_blk(q, b);
         for (int j = 0; j < SHA_BLOCK_BYTES; j++) st[j/8][8*(j%8)+:8] ^= q[b*SHA_BLOCK_BYTES+j];
         permute();
         exp = {st[5], st[4], st[3], st[2], st[1], st[0]};
         for (int i = 0; i < 400 && hash_out !== exp; i++) @(negedge clk_sys);
         chk(hash_out, exp, "digest");
      end
      chk(done, 1'b1, "done with final digest");
      chk(s_ready, 1'b1, "fifo drained");
   endtask
   task automatic end_of_test();
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // cuts a hang well past the longest expected run
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      end_of_test();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      chk({busy, done, padding_scheme_select}, '0, "reset state");
      chk(hash_out, '0, "reset digest");
      @(posedge clk_sys) {pad_select_nist, pad_select_keccak} <= 2'b11;
      @(posedge clk_sys) {pad_select_nist, pad_select_keccak} <= 2'b00;
      @(negedge clk_sys);
      chk(padding_scheme_select, 1'b1, "keccak should win");
      run_hash(0, 1'b0, 1'b1);
      run_hash(103, 1'b0, 1'b0);
      slow = 1'b1;
      run_hash(300, 1'b0, 1'b0);
      run_hash(150, 1'b1, 1'b0);
      // hold with a digest standing and stale words queued
      for (int i = 0; i < 8; i++) u_dma.push({rnd(), rnd(), rnd(), rnd()});
      repeat (6) @(posedge clk_sys);
      core_reset_hold <= 1'b1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk({s_ready, busy, done, padding_scheme_select}, '0, "hold clears");
      chk(hash_out, '0, "hold clears digest");
      @(posedge clk_sys) core_reset_hold <= 1'b0;
      run_hash(5, 1'b1, 1'b0);
      end_of_test();
   end
endmodule
bind sha_engine sha_engine_asserts u_chk (.clk_sys, .reset_n, .core_reset_hold, .start,
   .last_update, .pad_select_nist, .pad_select_keccak, .s_data, .s_valid, .s_ready, .busy,
   .done, .padding_scheme_select, .hash_out);
